// ==== hw/cfg_test_defines.vh ====
// Register offsets, page numbers and bit positions for the configuration and test bank.
`ifndef CFG_TEST_DEFINES_VH
`define CFG_TEST_DEFINES_VH
`define PAGE_CFG          2'h2
`define PAGE_TEST         2'h3
`define PAGE_SEL_ADDR     12'h0_100
`define STATUS_ADDR       12'h0_104
`define WO_ADDR           12'h0_108
`define OFS_CRC_HIGH      4'h1
`define OFS_CRC_LOW       4'h2
`define OFS_MOD_WIDTH     4'h4
`define OFS_RX_GAIN       4'h6
`define OFS_DRV_N         4'h7
`define OFS_CW_P          4'h8
`define OFS_MOD_P         4'h9
`define OFS_TMR_SET       4'ha
`define OFS_TMR_DIV       4'hb
`define OFS_RELOAD_HIGH   4'hc
`define OFS_RELOAD_LOW    4'hd
`define OFS_COUNT_HIGH    4'he
`define OFS_COUNT_LOW     4'hf
`define OFS_SEL_ONE       4'h1
`define OFS_SEL_TWO       4'h2
`define OFS_PIN_EN        4'h3
`define OFS_PIN_LEVEL     4'h4
`define OFS_TEST_BUS      4'h5
`define OFS_SELF_TEST     4'h6
`define OFS_VERSION       4'h7
`define OFS_AUX_PIN       4'h8
`define OFS_CONV_ONE      4'h9
`define OFS_CONV_TWO      4'ha
`define OFS_SAMPLER       4'hb
`define TMR_RUN_BIT       7
`define SELF_TEST_RUN_BIT 0
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// ==== hw/config_test_register_bank.v ====
// Configuration and test register pages behind an AXI4-Lite slave.
`timescale 1ns/1ps
`include "cfg_test_defines.vh"

// Overview of operation
// RQ1: Read/write bits hold exactly what the host last wrote and logic never alters them.
// RQ2: Dynamic bits take host writes but logic may overwrite them, as the self-test start bit does.
// RQ3: Read-only bits show internal state only and host writes leave them unchanged.
// RQ4: Write-only bits always read back as zero.
// RQ5: The host must not alter reserved bits and should write zero to them.
// RQ6: The host must leave reserved and production-test bits unchanged.
// RQ7: The latest CRC result is shown high byte at offset 1 and low byte at offset 2 of the configuration page.
// RQ8: The 16-bit timer reload value sits in host-writable offsets C and D.
// RQ9: The present 16-bit timer count is readable at offsets E and F.
// RQ10: The test pin enable register switches on each driver of D1 to D7 on its own.
// RQ11: The test pin level register gives the levels driven on D1 to D7.
// RQ12: Test page offsets C to F are for production tests only and not for host use.
// RQ13: Offset 6 of the test page controls the self-test and offset 7 reports the version.
// RQ14: Each register is eight bits wide and addressed by page plus in-page offset; page select, status and write-only sit at fixed addresses 100, 104, 108.
module config_test_register_bank #(
  // Version value is arbitrary.
  parameter [7:0] VERSION_CODE = 8'h5a,
  parameter       SELF_TEST_CYCLES = 64
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        nrst,
  // AXI4-Lite write address and data
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Internal sources
  input  wire [15:0] crc_value,
  input  wire        crc_valid,
  input  wire [7:0]  test_bus_in,
  input  wire [7:0]  sampler_iq_in,
  // Parallel data pins D1 to D7 in bits 7 to 1
  input  wire [7:0]  data_pin_in,
  output reg  [7:0]  data_pin_out,
  output reg  [7:0]  data_pin_oe,
  // Configuration outputs and timer expiry pulse
  output reg  [7:0]  modulation_width,
  output reg  [7:0]  receiver_gain_cfg,
  output reg  [7:0]  driver_n_conductance,
  output reg  [7:0]  carrier_p_conductance,
  output reg  [7:0]  modulation_p_conductance,
  output reg  [7:0]  aux_pin_control,
  output reg  [7:0]  test_converter_one_value,
  output reg  [7:0]  test_converter_two_value,
  output reg  [7:0]  test_signal_select_one,
  output reg  [7:0]  test_signal_select_two,
  output reg         timer_expired
);

  localparam ST_IDLE  = 2'b01;
  localparam ST_RESP  = 2'b10;

  reg [1:0]  page_reg;
  reg [15:0] crc_reg;
  reg        crc_done_flag_reg;
  reg [7:0]  timer_settings_reg;
  reg [7:0]  timer_divider_reg;
  reg [15:0] timer_reload_reg;
  reg [15:0] timer_count_reg;
  reg [7:0]  div_count_reg;
  reg [7:0]  self_test_control_reg;
  reg [7:0]  self_test_count_reg;
  reg [7:0]  test_pin_drive_enable_reg;
  reg [7:0]  test_pin_levels_reg;
  reg [7:0]  tbus_s1_reg;
  reg [7:0]  tbus_s2_reg;
  reg [7:0]  samp_s1_reg;
  reg [7:0]  samp_s2_reg;
  reg [7:0]  pin_s1_reg;
  reg [7:0]  pin_s2_reg;
  reg [1:0]  wstate_reg;
  reg        aw_have_reg;
  reg        w_have_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg        wstrb0_reg;
  reg [7:0]  rd_byte;
  reg        rd_hit;
  reg        wr_hit;

  wire       aw_take = s_axi_awvalid & s_axi_awready;
  wire       w_take  = s_axi_wvalid & s_axi_wready;
  wire       wr_go   = wstate_reg == ST_IDLE & aw_have_reg & w_have_reg;
  wire [7:0] wbyte   = wdata_reg[7:0];
  wire       wr_ok   = wr_go & wr_hit & wstrb0_reg;
  wire [3:0] wofs    = awaddr_reg[5:2];
  wire [1:0] wpg     = awaddr_reg[7:6];
  wire       tick    = timer_settings_reg[`TMR_RUN_BIT] &
                       (div_count_reg == timer_divider_reg);

  // RQ14 page decode.
  always @* begin
    wr_hit = 1'b0;
    if (awaddr_reg[11:8] == 4'h0) begin
      case (wpg)
        `PAGE_CFG: wr_hit = wofs == `OFS_MOD_WIDTH | wofs == `OFS_RX_GAIN |
                            wofs == `OFS_DRV_N | wofs == `OFS_CW_P |
                            wofs == `OFS_MOD_P | wofs == `OFS_TMR_SET |
                            wofs == `OFS_TMR_DIV | wofs == `OFS_RELOAD_HIGH |
                            wofs == `OFS_RELOAD_LOW | wofs == `OFS_CRC_HIGH |
                            wofs == `OFS_CRC_LOW | wofs == `OFS_COUNT_HIGH |
                            wofs == `OFS_COUNT_LOW;
        `PAGE_TEST: wr_hit = wofs >= `OFS_SEL_ONE & wofs <= `OFS_SAMPLER;
        default: wr_hit = 1'b0;
      endcase
    end else begin
      wr_hit = awaddr_reg == `PAGE_SEL_ADDR | awaddr_reg == `WO_ADDR |
               awaddr_reg == `STATUS_ADDR;
    end
  end

  // Write channel handshake and response.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 12'h0_000;
      wdata_reg     <= 32'h0000_0000;
      wstrb0_reg    <= 1'b0;
      wstate_reg    <= ST_IDLE;
    end else begin
      if (aw_take) begin
        awaddr_reg    <= s_axi_awaddr;
        aw_have_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        wdata_reg    <= s_axi_wdata;
        wstrb0_reg   <= s_axi_wstrb[0];
        w_have_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      case (wstate_reg)
        ST_IDLE: begin
          if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            wstate_reg   <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            wstate_reg    <= ST_IDLE;
          end
        end
        default: wstate_reg <= ST_IDLE;
      endcase
    end
  end

  // RQ1 plain host registers.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      page_reg                  <= 2'h0;
      modulation_width          <= 8'h00;
      receiver_gain_cfg         <= 8'h00;
      driver_n_conductance      <= 8'h00;
      carrier_p_conductance     <= 8'h00;
      modulation_p_conductance  <= 8'h00;
      timer_settings_reg        <= 8'h00;
      timer_divider_reg         <= 8'h00;
      timer_reload_reg          <= 16'h0000;
      test_signal_select_one    <= 8'h00;
      test_signal_select_two    <= 8'h00;
      test_pin_drive_enable_reg <= 8'h00;
      test_pin_levels_reg       <= 8'h00;
      aux_pin_control           <= 8'h00;
      test_converter_one_value  <= 8'h00;
      test_converter_two_value  <= 8'h00;
    end else if (wr_ok) begin
      if (awaddr_reg == `PAGE_SEL_ADDR) begin
        page_reg <= wbyte[1:0];
      end else if (awaddr_reg[11:8] == 4'h0 && wpg == `PAGE_CFG) begin
        case (wofs)
          `OFS_MOD_WIDTH:   modulation_width         <= wbyte;
          `OFS_RX_GAIN:     receiver_gain_cfg        <= wbyte;
          `OFS_DRV_N:       driver_n_conductance     <= wbyte;
          `OFS_CW_P:        carrier_p_conductance    <= wbyte;
          `OFS_MOD_P:       modulation_p_conductance <= wbyte;
          `OFS_TMR_SET:     timer_settings_reg       <= wbyte;
          `OFS_TMR_DIV:     timer_divider_reg        <= wbyte;
          // RQ8 reload pair write.
          `OFS_RELOAD_HIGH: timer_reload_reg[15:8]   <= wbyte;
          `OFS_RELOAD_LOW:  timer_reload_reg[7:0]    <= wbyte;
          default: ;
        endcase
      end else if (awaddr_reg[11:8] == 4'h0 && wpg == `PAGE_TEST) begin
        case (wofs)
          `OFS_SEL_ONE:   test_signal_select_one    <= wbyte;
          `OFS_SEL_TWO:   test_signal_select_two    <= wbyte;
          `OFS_PIN_EN:    test_pin_drive_enable_reg <= wbyte;
          `OFS_PIN_LEVEL: test_pin_levels_reg       <= wbyte;
          `OFS_AUX_PIN:   aux_pin_control           <= wbyte;
          `OFS_CONV_ONE:  test_converter_one_value  <= wbyte;
          `OFS_CONV_TWO:  test_converter_two_value  <= wbyte;
          default: ;
        endcase
      end
    end
  end

  // RQ2 self-test start bit clears itself.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      self_test_control_reg <= 8'h00;
      self_test_count_reg   <= 8'h00;
    end else if (wr_ok && awaddr_reg[11:8] == 4'h0 && wpg == `PAGE_TEST &&
                 wofs == `OFS_SELF_TEST) begin
      // RQ13 self-test control write.
      self_test_control_reg <= wbyte;
      self_test_count_reg   <= 8'h00;
    end else if (self_test_control_reg[`SELF_TEST_RUN_BIT]) begin
      if (self_test_count_reg == SELF_TEST_CYCLES - 1) begin
        self_test_control_reg[`SELF_TEST_RUN_BIT] <= 1'b0;
      end else begin
        self_test_count_reg <= self_test_count_reg + 8'h01;
      end
    end
  end

  // RQ3 CRC capture and done flag.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      crc_reg           <= 16'h0000;
      crc_done_flag_reg <= 1'b0;
    end else if (crc_valid) begin
      crc_reg           <= crc_value;
      crc_done_flag_reg <= 1'b1;
    end
  end

  // RQ9 timer count.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_count_reg   <= 8'h00;
      timer_count_reg <= 16'h0000;
      timer_expired   <= 1'b0;
    end else begin
      timer_expired <= 1'b0;
      if (!timer_settings_reg[`TMR_RUN_BIT]) begin
        div_count_reg   <= 8'h00;
        timer_count_reg <= timer_reload_reg;
      end else if (tick) begin
        div_count_reg <= 8'h00;
        if (timer_count_reg == 16'h0000) begin
          timer_count_reg <= timer_reload_reg;
          timer_expired   <= 1'b1;
        end else begin
          timer_count_reg <= timer_count_reg - 16'h0001;
        end
      end else begin
        div_count_reg <= div_count_reg + 8'h01;
      end
    end
  end

  // Pin and internal bus synchronisers; RQ10 RQ11 pin drivers.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tbus_s1_reg  <= 8'h00;
      tbus_s2_reg  <= 8'h00;
      samp_s1_reg  <= 8'h00;
      samp_s2_reg  <= 8'h00;
      pin_s1_reg   <= 8'h00;
      pin_s2_reg   <= 8'h00;
      data_pin_out <= 8'h00;
      data_pin_oe  <= 8'h00;
    end else begin
      tbus_s1_reg  <= test_bus_in;
      tbus_s2_reg  <= tbus_s1_reg;
      samp_s1_reg  <= sampler_iq_in;
      samp_s2_reg  <= samp_s1_reg;
      pin_s1_reg   <= data_pin_in;
      pin_s2_reg   <= pin_s1_reg;
      data_pin_oe  <= {test_pin_drive_enable_reg[7:1], 1'b0};
      data_pin_out <= {test_pin_levels_reg[7:1], 1'b0};
    end
  end

  // RQ7 RQ9 RQ13 read mux.
  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (s_axi_araddr == `PAGE_SEL_ADDR) begin
      rd_byte = {6'h00, page_reg};
    end else if (s_axi_araddr == `STATUS_ADDR) begin
      rd_byte = {7'h00, crc_done_flag_reg};
    end else if (s_axi_araddr == `WO_ADDR) begin
      // RQ4 write-only reads zero.
      rd_byte = 8'h00;
    end else if (s_axi_araddr[11:8] != 4'h0) begin
      rd_hit = 1'b0;
    end else if (s_axi_araddr[7:6] == `PAGE_CFG) begin
      case (s_axi_araddr[5:2])
        `OFS_CRC_HIGH:    rd_byte = crc_reg[15:8];
        `OFS_CRC_LOW:     rd_byte = crc_reg[7:0];
        `OFS_MOD_WIDTH:   rd_byte = modulation_width;
        `OFS_RX_GAIN:     rd_byte = receiver_gain_cfg;
        `OFS_DRV_N:       rd_byte = driver_n_conductance;
        `OFS_CW_P:        rd_byte = carrier_p_conductance;
        `OFS_MOD_P:       rd_byte = modulation_p_conductance;
        `OFS_TMR_SET:     rd_byte = timer_settings_reg;
        `OFS_TMR_DIV:     rd_byte = timer_divider_reg;
        `OFS_RELOAD_HIGH: rd_byte = timer_reload_reg[15:8];
        `OFS_RELOAD_LOW:  rd_byte = timer_reload_reg[7:0];
        `OFS_COUNT_HIGH:  rd_byte = timer_count_reg[15:8];
        `OFS_COUNT_LOW:   rd_byte = timer_count_reg[7:0];
        default:          rd_hit  = 1'b0;
      endcase
    end else if (s_axi_araddr[7:6] == `PAGE_TEST) begin
      case (s_axi_araddr[5:2])
        `OFS_SEL_ONE:   rd_byte = test_signal_select_one;
        `OFS_SEL_TWO:   rd_byte = test_signal_select_two;
        `OFS_PIN_EN:    rd_byte = test_pin_drive_enable_reg;
        `OFS_PIN_LEVEL: rd_byte = test_pin_levels_reg;
        `OFS_TEST_BUS:  rd_byte = tbus_s2_reg;
        `OFS_SELF_TEST: rd_byte = self_test_control_reg;
        `OFS_VERSION:   rd_byte = VERSION_CODE;
        `OFS_AUX_PIN:   rd_byte = aux_pin_control;
        `OFS_CONV_ONE:  rd_byte = test_converter_one_value;
        `OFS_CONV_TWO:  rd_byte = test_converter_two_value;
        `OFS_SAMPLER:   rd_byte = samp_s2_reg;
        default:        rd_hit  = 1'b0;
      endcase
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ==== test/cfg_bank_props.sv ====
// Bus and register checks for the configuration and test bank.
`timescale 1ns/1ps
module cfg_bank_props #(
  // Version value is arbitrary.
  parameter [7:0] VERSION_CODE = 8'h5a
) (
  // Clock and reset
  input wire        ref_clk,
  input wire        nrst,
  // Bus signals
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Pins
  input wire [7:0]  data_pin_out,
  input wire [7:0]  data_pin_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("Write response late.");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("Read response late.");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped.");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped.");
  a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
    else $error("Upper read bits set.");
  a_pin_zero: assert property (!data_pin_oe[0] && !data_pin_out[0])
    else $error("Pin bit zero driven.");
  a_version_read: assert property (s_rd_taken ##0 s_axi_araddr == 12'h0dc
    |=> s_axi_rdata[7:0] == VERSION_CODE)
    else $error("Version mismatch.");
  a_wo_zero: assert property (s_rd_taken ##0 s_axi_araddr == 12'h108
    |=> s_axi_rdata == 0)
    else $error("Write-only bits read nonzero.");
  a_unmapped_err: assert property (s_rd_taken ##0 s_axi_araddr == 12'h0f0
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
    else $error("Unmapped read not refused.");
endmodule

bind config_test_register_bank cfg_bank_props #(
  .VERSION_CODE(VERSION_CODE)
) i_props (
  .ref_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_pin_out, .data_pin_oe
);

// ==== test/host_model.sv ====
// Host model driving the bus master side of the register bank.
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire        ref_clk,
  // Write channels
  output reg  [11:0] s_axi_awaddr,
  output reg         s_axi_awvalid,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata,
  output reg  [3:0]  s_axi_wstrb,
  output reg         s_axi_wvalid,
  input  wire        s_axi_wready,
  input  wire        s_axi_bvalid,
  output reg         s_axi_bready,
  // Read channels
  output reg  [11:0] s_axi_araddr,
  output reg         s_axi_arvalid,
  input  wire        s_axi_arready,
  input  wire        s_axi_rvalid,
  output reg         s_axi_rready
);
  reg aw_d;
  reg w_d;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
    s_axi_wstrb = 4'hf;
  end
  // Released lines carry the inverse value.
  task wr(input [11:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      aw_d = 1'b0;
      w_d = 1'b0;
      while (!(aw_d && w_d)) begin
        @(posedge ref_clk);
        if (s_axi_awready && !aw_d) begin
          aw_d = 1'b1;
          s_axi_awvalid <= 1'b0;
          s_axi_awaddr <= ~a;
        end
        if (s_axi_wready && !w_d) begin
          w_d = 1'b1;
          s_axi_wvalid <= 1'b0;
          s_axi_wdata <= ~d;
        end
      end
      while (!s_axi_bvalid) @(posedge ref_clk);
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [11:0] a);
    begin
      @(posedge ref_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      @(posedge ref_clk);
      while (!s_axi_arready) @(posedge ref_clk);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      while (!s_axi_rvalid) @(posedge ref_clk);
      s_axi_rready <= 1'b0;
    end
  endtask
endmodule

// ==== test/config_test_register_bank_bench.sv ====
// Self-checking bench for the configuration and test register bank.
`timescale 1ns/1ps
module config_test_register_bank_bench;
  // Version value is arbitrary.
  localparam [7:0] VER = 8'h3c;
  reg         ref_clk;
  reg         nrst;
  reg  [15:0] crc_value;
  reg         crc_valid;
  reg  [7:0]  test_bus_in, sampler_iq_in;
  wire [11:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0]  s_axi_wstrb;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire        s_axi_rvalid, s_axi_rready, timer_expired;
  wire [7:0]  data_pin_out, data_pin_oe, modulation_width;
  wire [7:0]  receiver_gain_cfg, driver_n_conductance, aux_pin_control;
  wire [7:0]  carrier_p_conductance, modulation_p_conductance;
  wire [7:0]  test_converter_one_value, test_converter_two_value;
  wire [7:0]  test_signal_select_one, test_signal_select_two;
  reg  [33:0] exq[$];
  reg  [31:0] seed;
  reg  [7:0]  v[0:31];
  integer     error_cnt, num_checks, cyc, i;
  config_test_register_bank #(.VERSION_CODE(VER), .SELF_TEST_CYCLES(16)) i_dut (
    .ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .crc_value, .crc_valid, .test_bus_in, .sampler_iq_in,
    .data_pin_in(8'h00), .data_pin_out, .data_pin_oe, .modulation_width,
    .receiver_gain_cfg, .driver_n_conductance, .carrier_p_conductance,
    .modulation_p_conductance, .aux_pin_control, .test_converter_one_value,
    .test_converter_two_value, .test_signal_select_one,
    .test_signal_select_two, .timer_expired);
  host_model i_host (
    .ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready);
  function [31:0] xs(input [31:0] x);
    reg [31:0] t;
    begin
      t = x ^ (x << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [11:0] ad(input [1:0] p, input [3:0] o);
    ad = {4'h0, p, o, 2'b00};
  endfunction
  task complete_run;
    begin
      if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [33:0] got, input [33:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        error_cnt++;
        $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wrx(input [11:0] a, input [31:0] d, input [1:0] r);
    begin
      exq.push_back({r, 32'h0});
      i_host.wr(a, {24'h00_0000, d[7:0]});
    end
  endtask
  task rdx(input [11:0] a, input [33:0] e);
    begin
      exq.push_back(e);
      i_host.rd(a);
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run;
    end
  end
  always @(posedge ref_clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      chk({s_axi_bresp, 32'h0}, exq[0]);
      void'(exq.pop_front());
    end
    if (s_axi_rvalid && s_axi_rready) begin
      chk({s_axi_rresp, s_axi_rdata}, exq[0]);
      void'(exq.pop_front());
    end
  end
  initial begin
    {nrst, crc_value, crc_valid, test_bus_in, sampler_iq_in} = 0;
    {error_cnt, num_checks, cyc} = 0;
    seed = 32'd64020;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    for (i = 0; i < 32; i++) if (32'h071e_3fd0 >> i & 1) begin
      seed = xs(seed);
      v[i] = seed[7:0];
      wrx(ad({1'b1, i[4]}, i[3:0]), seed, 2'h0);
    end
    for (i = 0; i < 32; i++) if (32'h071e_3fd0 >> i & 1)
      rdx(ad({1'b1, i[4]}, i[3:0]), {26'h0, v[i]});
    chk({2'h0, modulation_width, receiver_gain_cfg, driver_n_conductance,
      carrier_p_conductance}, {2'h0, v[4], v[6], v[7], v[8]});
    chk({2'h0, modulation_p_conductance, aux_pin_control,
      test_converter_one_value, test_converter_two_value},
      {2'h0, v[9], v[24], v[25], v[26]});
    chk({18'h0, test_signal_select_one, test_signal_select_two},
      {18'h0, v[17], v[18]});
    chk({18'h0, data_pin_oe, data_pin_out},
      {18'h0, v[19] & 8'hfe, v[20] & 8'hfe});
    seed = xs(seed);
    crc_value <= seed[15:0];
    crc_valid <= 1'b1;
    {sampler_iq_in, test_bus_in} <= seed[31:16];
    @(posedge ref_clk);
    crc_valid <= 1'b0;
    wrx(ad(2'h2, 4'ha), 32'h0, 2'h0);
    {v[1], v[2], v[14], v[15]} = {seed[15:0], v[12], v[13]};
    {v[21], v[23], v[27]} = {seed[23:16], VER, seed[31:24]};
    for (i = 0; i < 32; i++) if (32'h08a0_c006 >> i & 1) begin
      wrx(ad({1'b1, i[4]}, i[3:0]), {24'h0, ~v[i]}, 2'h0);
      rdx(ad({1'b1, i[4]}, i[3:0]), {26'h0, v[i]});
    end
    rdx(12'h104, 34'h1);
    wrx(12'h108, seed, 2'h0);
    rdx(12'h108, 34'h0);
    wrx(12'h100, 32'h2, 2'h0);
    rdx(12'h100, 34'h2);
    for (i = 12; i < 16; i++) begin
      wrx(ad(2'h3, i[3:0]), seed, 2'h2);
      rdx(ad(2'h3, i[3:0]), {2'h2, 32'h0});
    end
    wrx(ad(2'h3, 4'h6), 32'h1, 2'h0);
    rdx(ad(2'h3, 4'h6), 34'h1);
    repeat (20) @(posedge ref_clk);
    rdx(ad(2'h3, 4'h6), 34'h0);
    wrx(ad(2'h2, 4'hc), 32'h0, 2'h0);
    wrx(ad(2'h2, 4'hd), 32'h3, 2'h0);
    wrx(ad(2'h2, 4'hb), 32'h0, 2'h0);
    wrx(ad(2'h2, 4'ha), 32'h80, 2'h0);
    i = 0;
    while (timer_expired !== 1'b1 && i < 40) begin
      @(posedge ref_clk);
      i++;
    end
    chk({33'h0, timer_expired}, 34'h1);
    complete_run;
  end
endmodule
